// [rtl/bus_area_config_pkg.sv]
// shared constants for the bus area configuration register bank
package bus_area_config_pkg;

    // ------------------------------------------------------------
    // register addresses (32-bit access; 16-bit access adds two)
    // ------------------------------------------------------------
    localparam logic [31:0] BUS_CONTROL_ONE_ADDR = 32'hfffffe0;
    localparam logic [31:0] BUS_CONTROL_TWO_ADDR = 32'hfffffe4;
    localparam logic [31:0] HALF_ACCESS_OFFSET   = 32'h0000002;
    localparam logic [15:0] WRITE_KEY            = 16'ha55a;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [15:0] BUS_CONTROL_ONE_RESET = 16'h03f0;
    localparam logic [15:0] BUS_CONTROL_TWO_RESET = 16'h00fc;

    // ------------------------------------------------------------
    // first register field positions
    // ------------------------------------------------------------
    localparam int ROLE_POS         = 15;
    localparam int ENDIAN_POS       = 12;
    localparam int BURST_ROM_POS    = 11;
    localparam int SHARE_POS        = 10;
    localparam int AREA23_WAIT_LSB  = 8;
    localparam int AREA1_WAIT_LSB   = 6;
    localparam int AREA0_WAIT_LSB   = 4;
    localparam int MEMTYPE_LSB      = 0;

    // writable bits of each register
    localparam logic [15:0] BUS_CONTROL_ONE_WMASK = 16'h1ff7;
    localparam logic [15:0] BUS_CONTROL_TWO_WMASK = 16'h00fc;

    // ------------------------------------------------------------
    // second register field positions
    // ------------------------------------------------------------
    localparam int AREA3_WIDTH_LSB = 6;
    localparam int AREA2_WIDTH_LSB = 4;
    localparam int AREA1_WIDTH_LSB = 2;

    // ------------------------------------------------------------
    // encodings
    // ------------------------------------------------------------
    localparam logic [1:0] WIDTH_RESERVED = 2'h0;
    localparam logic [1:0] WIDTH_BYTE     = 2'h1;
    localparam logic [1:0] WIDTH_WORD     = 2'h2;
    localparam logic [1:0] WIDTH_LONG     = 2'h3;
    localparam logic [2:0] LONG_WAIT_BASE = 3'h3;

    typedef enum logic [2:0]
    {
        MEM_BOTH_ORDINARY = 3'h0,
        MEM_AREA3_SDRAM   = 3'h1,
        MEM_AREA3_DRAM    = 3'h2,
        MEM_AREA3_PSRAM   = 3'h3,
        MEM_AREA2_SDRAM   = 3'h4,
        MEM_BOTH_SDRAM    = 3'h5
    } memtype_t;

endpackage

// [rtl/bus_area_config_regs.sv]
// bus area configuration register bank with decoded area settings
`timescale 1ns/100ps
// Overview of operation
// - bit 15 shows arbitration role from mode pin, read only, 1 means slave
// - first register bits 14, 13 and 3 read zero; software writes zero
// - endian bit 12 set makes area 2 transfers little-endian
// - burst ROM bit 11 selects burst ROM cycles for area 0
// - master mode with share bit: only area 2 shared, others request no bus
// - share bit set disables address monitor; resets to zero
// - bits 9:8 give areas 2 and 3 long wait, 3 to 6, reset 6
// - bits 7:6 give area 1 long wait, 3 to 6, reset 6
// - bits 5:4 give area 0 long wait, 3 to 6, reset 6
// - bits 2:0 select memory types of areas 2 and 3
// - second register bits 7:6 set area 3 width when ordinary
// - bits 5:4 set area 2 width when ordinary
// - bits 3:2 set area 1 width, reset 32-bit
// - second register bits 15:8 and 1:0 read zero
// - area 0 width comes from mode pins
// - 32-bit writes need key in upper half; 32-bit reads upper zero
// - 16-bit accesses read only; writes ignored
module bus_area_config_regs
    import bus_area_config_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic        slaveModePin,
    input  wire logic [1:0]  area0WidthPins,
    input  wire logic        busSelect,
    input  wire logic        busWrite,
    input  wire logic        busLong,
    input  wire logic [31:0] busAddr,
    input  wire logic [31:0] busWriteData,
    output logic      [31:0] busReadData,
    output logic             busHit,
    output logic             area2LittleEndian,
    output logic             area0BurstRom,
    output logic             partialShareMaster,
    output logic             addressMonitorEn,
    output logic [3:0]       areaShared,
    output logic [2:0]       area0LongWait,
    output logic [2:0]       area1LongWait,
    output logic [2:0]       area23LongWait,
    output logic             area2Sdram,
    output logic             area3Sdram,
    output logic             area3Dram,
    output logic             area3Psram,
    output logic [1:0]       area0Width,
    output logic [1:0]       area1Width,
    output logic [1:0]       area2Width,
    output logic [1:0]       area3Width
);

    // ------------------------------------------------------------
    // mode pin synchronisers
    // ------------------------------------------------------------
    logic [2:0] roleSync;
    logic [2:0] next_roleSync;
    logic [1:0] widthSync [3];
    logic [1:0] next_widthSync [3];
    logic       role;
    logic       next_role;
    logic [1:0] width0;
    logic [1:0] next_width0;

    always_comb
    begin
        next_roleSync     = {roleSync[1:0], slaveModePin};
        next_widthSync[0] = area0WidthPins;
        next_widthSync[1] = widthSync[0];
        next_widthSync[2] = widthSync[1];
        next_role         = (roleSync[1] == roleSync[2]) ? roleSync[2] : role;
        next_width0       = (widthSync[1] == widthSync[2]) ? widthSync[2] : width0;
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            roleSync     <= 3'h0;
            widthSync[0] <= WIDTH_LONG;
            widthSync[1] <= WIDTH_LONG;
            widthSync[2] <= WIDTH_LONG;
            role         <= 1'b0;
            width0       <= WIDTH_LONG;
        end
        else
        begin
            roleSync  <= next_roleSync;
            widthSync <= next_widthSync;
            role      <= next_role;
            width0    <= next_width0;
        end
    end

    // ------------------------------------------------------------
    // register storage and access
    // ------------------------------------------------------------
    logic [15:0] ctrlOne;
    logic [15:0] ctrlTwo;
    logic [15:0] next_ctrlOne;
    logic [15:0] next_ctrlTwo;
    logic [31:0] next_busReadData;
    logic        next_busHit;

    function automatic logic [1:0] decode_reg(input logic [31:0] addr, input logic long_acc);
        logic [31:0] base;
        base = long_acc ? addr : addr - HALF_ACCESS_OFFSET;
        if (base == BUS_CONTROL_ONE_ADDR)
            decode_reg = 2'h1;
        else if (base == BUS_CONTROL_TWO_ADDR)
            decode_reg = 2'h2;
        else
            decode_reg = 2'h0;
    endfunction

    logic [1:0] regSel;
    logic       keyedWrite;
    logic [15:0] viewOne;

    always_comb
    begin
        regSel       = decode_reg(busAddr, busLong);
        keyedWrite   = busSelect & busWrite & busLong & (busWriteData[31:16] == WRITE_KEY);
        viewOne      = ctrlOne & BUS_CONTROL_ONE_WMASK;
        viewOne[ROLE_POS] = role;
        next_ctrlOne = ctrlOne;
        next_ctrlTwo = ctrlTwo;
        if (keyedWrite && regSel == 2'h1)
            next_ctrlOne = busWriteData[15:0] & BUS_CONTROL_ONE_WMASK;
        else if (keyedWrite && regSel == 2'h2)
            next_ctrlTwo = busWriteData[15:0] & BUS_CONTROL_TWO_WMASK;
        next_busHit      = busSelect & (regSel != 2'h0);
        next_busReadData = busReadData;
        if (busSelect && !busWrite)
        begin
            if (regSel == 2'h1)
                next_busReadData = {16'h0000, viewOne};
            else if (regSel == 2'h2)
                next_busReadData = {16'h0000, ctrlTwo & BUS_CONTROL_TWO_WMASK};
            else
                next_busReadData = 32'h00000000;
        end
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            ctrlOne     <= BUS_CONTROL_ONE_RESET;
            ctrlTwo     <= BUS_CONTROL_TWO_RESET;
            busReadData <= 32'h00000000;
            busHit      <= 1'b0;
        end
        else
        begin
            ctrlOne     <= next_ctrlOne;
            ctrlTwo     <= next_ctrlTwo;
            busReadData <= next_busReadData;
            busHit      <= next_busHit;
        end
    end

    // ------------------------------------------------------------
    // decoded settings for the bus cycle engines
    // ------------------------------------------------------------
    memtype_t memType;
    logic     area2Ordinary;
    logic     area3Ordinary;

    always_comb
    begin
        memType            = memtype_t'(ctrlOne[MEMTYPE_LSB +: 3]);
        area2LittleEndian  = ctrlOne[ENDIAN_POS];
        area0BurstRom      = ctrlOne[BURST_ROM_POS];
        partialShareMaster = !role && ctrlOne[SHARE_POS];
        addressMonitorEn   = !ctrlOne[SHARE_POS];
        // slave role shares nothing by request; master shares only area 2 with share bit set, all areas otherwise
        areaShared         = role ? 4'h0 : (partialShareMaster ? 4'h4 : 4'hf);
        area23LongWait     = LONG_WAIT_BASE + {1'b0, ctrlOne[AREA23_WAIT_LSB +: 2]};
        area1LongWait      = LONG_WAIT_BASE + {1'b0, ctrlOne[AREA1_WAIT_LSB +: 2]};
        area0LongWait      = LONG_WAIT_BASE + {1'b0, ctrlOne[AREA0_WAIT_LSB +: 2]};
        area2Sdram         = (memType == MEM_AREA2_SDRAM) || (memType == MEM_BOTH_SDRAM);
        area3Sdram         = (memType == MEM_AREA3_SDRAM) || (memType == MEM_BOTH_SDRAM);
        area3Dram          = (memType == MEM_AREA3_DRAM);
        area3Psram         = (memType == MEM_AREA3_PSRAM);
        area2Ordinary      = !area2Sdram;
        area3Ordinary      = !(area3Sdram || area3Dram || area3Psram);
        area3Width         = area3Ordinary ? ctrlTwo[AREA3_WIDTH_LSB +: 2] : WIDTH_LONG;
        area2Width         = area2Ordinary ? ctrlTwo[AREA2_WIDTH_LSB +: 2] : WIDTH_LONG;
        area1Width         = ctrlTwo[AREA1_WIDTH_LSB +: 2];
        area0Width         = width0;
    end

endmodule

// [tb/bus_area_config_chk.sv]
// concurrent checks on the ports of the bus area configuration register bank
`timescale 1ns/100ps
module bus_area_config_chk
    import bus_area_config_pkg::*;
(
    input wire logic        clk,
    input wire logic        reset,
    input wire logic        busSelect,
    input wire logic        busWrite,
    input wire logic        busLong,
    input wire logic [31:0] busAddr,
    input wire logic [31:0] busWriteData,
    input wire logic [31:0] busReadData,
    input wire logic        busHit,
    input wire logic        area2LittleEndian,
    input wire logic        area0BurstRom,
    input wire logic        partialShareMaster,
    input wire logic        addressMonitorEn,
    input wire logic [3:0]  areaShared,
    input wire logic [2:0]  area23LongWait,
    input wire logic [1:0]  area1Width,
    input wire logic        area3Sdram,
    input wire logic        area3Dram,
    input wire logic        area3Psram
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    wire logic mapped = busAddr[31:3] == BUS_CONTROL_ONE_ADDR[31:3] && busAddr[1:0] == {!busLong, 1'b0};
    sequence keyed;
        busSelect && busWrite && busLong && busWriteData[31:16] == WRITE_KEY;
    endsequence
    sequence dropped;
        busSelect && busWrite && (!busLong || busWriteData[31:16] != WRITE_KEY);
    endsequence
    chk_hit_mapped: assert property (busSelect && mapped |=> busHit)
        else $error("no hit after mapped access");
    chk_hit_idle: assert property (!busSelect |=> !busHit)
        else $error("hit without access");
    chk_upper_zero: assert property (busHit |-> busReadData[31:16] == 16'h0)
        else $error("upper read half not zero");
    chk_write_one: assert property (keyed ##0 busAddr == BUS_CONTROL_ONE_ADDR |=>
        area2LittleEndian == $past(busWriteData[12]) && area0BurstRom == $past(busWriteData[11])
        && area23LongWait == 3'h3 + $past(busWriteData[9:8])) else $error("first register write lost");
    chk_write_two: assert property (keyed ##0 busAddr == BUS_CONTROL_TWO_ADDR |=>
        area1Width == $past(busWriteData[3:2])) else $error("second register write lost");
    chk_bad_drop: assert property (dropped |=> $stable(area1Width) && $stable(area23LongWait))
        else $error("unkeyed write took effect");
    chk_share_mask: assert property (partialShareMaster |-> areaShared == 4'h4 && !addressMonitorEn)
        else $error("partial share mask wrong");
    chk_type_excl: assert property ($onehot0({area3Sdram, area3Dram, area3Psram}))
        else $error("area 3 type not exclusive");
endmodule
bind bus_area_config_regs bus_area_config_chk u_bus_area_config_chk (.*);

// [tb/tb.sv]
// self-checking bench for the bus area configuration register bank
`timescale 1ns/100ps
module tb
    import bus_area_config_pkg::*;
;
    logic        clk, reset, slaveModePin, busSelect, busWrite, busLong, busHit;
    logic        area2LittleEndian, area0BurstRom, partialShareMaster, addressMonitorEn;
    logic        area2Sdram, area3Sdram, area3Dram, area3Psram;
    logic [1:0]  area0WidthPins, area0Width, area1Width, area2Width, area3Width;
    logic [2:0]  area0LongWait, area1LongWait, area23LongWait;
    logic [3:0]  areaShared;
    logic [31:0] busAddr, busWriteData, busReadData;
    int          mismatches, n_tests;
    // address, written half, expected read
    logic [31:0] rows [6][3] = '{'{BUS_CONTROL_ONE_ADDR, 32'hffff, 32'h1ff7},
        '{BUS_CONTROL_ONE_ADDR, 32'h6a5c, 32'h0a54}, '{BUS_CONTROL_ONE_ADDR, 32'h0000, 32'h0000},
        '{BUS_CONTROL_TWO_ADDR, 32'hffff, 32'h00fc}, '{BUS_CONTROL_TWO_ADDR, 32'h00a8, 32'h00a8},
        '{BUS_CONTROL_TWO_ADDR, 32'h0054, 32'h0054}};
    bus_area_config_regs u_bus_area_config_regs (.*);
    initial
    begin
        clk = 0;
        forever #2.5 clk = ~clk;
    end
    task automatic ck(input logic [32:0] got, exp);
        n_tests++;
        if (got !== exp)
        begin
            mismatches++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic acc(input logic w, l, input logic [31:0] a, d);
        @(posedge clk);
        #1;
        {busSelect, busWrite, busLong, busAddr, busWriteData} = {1'b1, w, l, a, d};
        @(posedge clk);
        #1;
        busSelect = 0;
    endtask
    task automatic rd(input logic [31:0] a, exp);
        acc(0, 0, a + HALF_ACCESS_OFFSET, 32'h0);
        ck({busHit, busReadData}, {1'b1, exp});
    endtask
    task automatic summarize;
        $display("checks=%0d mismatches=%0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial
    begin
        {slaveModePin, busSelect, busWrite, busLong, busAddr, busWriteData} = '0;
        area0WidthPins = 2'h2;
        reset = 1;
        repeat (20) @(posedge clk);
        #1;
        reset = 0;
        rd(BUS_CONTROL_ONE_ADDR, 32'h03f0);
        rd(BUS_CONTROL_TWO_ADDR, 32'h00fc);
        ck({area0LongWait, area1LongWait, area23LongWait, area1Width}, {3'h6, 3'h6, 3'h6, 2'h3});
        ck(area0Width, 2'h2);
        // only register accesses are made, so no area other than area 0 is touched before set-up
        for (int i = 0; i < 6; i++)
        begin
            acc(1, 1, rows[i][0], {WRITE_KEY, rows[i][1][15:0]});
            rd(rows[i][0], rows[i][2]);
        end
        for (int i = 0; i < 8; i++)
        begin
            logic [2:0] c;
            logic       s2, s3;
            c = i[2:0];
            s2 = c == 3'h4 || c == 3'h5;
            s3 = c == 3'h1 || c == 3'h5;
            acc(1, 1, BUS_CONTROL_ONE_ADDR, {WRITE_KEY, 3'h0, c, c[1:0], c[1:0], c[1:0], 1'b0, c});
            ck({area2LittleEndian, area0BurstRom, partialShareMaster, addressMonitorEn, areaShared},
                {c[2], c[1], c[0], !c[0], c[0] ? 4'h4 : 4'hf});
            ck({area0LongWait, area1LongWait, area23LongWait}, {3{3'h3 + c[1:0]}});
            ck({area2Sdram, area3Sdram, area3Dram, area3Psram, area2Width, area3Width}, {s2, s3, c == 3'h2,
                c == 3'h3, s2 ? 2'h3 : 2'h1, (s3 || c == 3'h2 || c == 3'h3) ? 2'h3 : 2'h1});
        end
        acc(1, 0, BUS_CONTROL_TWO_ADDR + HALF_ACCESS_OFFSET, {WRITE_KEY, 16'h00fc});
        rd(BUS_CONTROL_TWO_ADDR, 32'h0054);
        acc(1, 1, BUS_CONTROL_TWO_ADDR, 32'h5aa500fc);
        rd(BUS_CONTROL_TWO_ADDR, 32'h0054);
        acc(1, 1, BUS_CONTROL_TWO_ADDR, {WRITE_KEY, 16'h0054});
        rd(BUS_CONTROL_TWO_ADDR, 32'h0054);
        acc(0, 1, BUS_CONTROL_TWO_ADDR + 32'h8, 32'h0);
        ck({busHit, busReadData}, 33'h0);
        slaveModePin = 1;
        repeat (6) @(posedge clk);
        acc(1, 1, BUS_CONTROL_ONE_ADDR, {WRITE_KEY, 16'h0400});
        rd(BUS_CONTROL_ONE_ADDR, 32'h8400);
        ck({partialShareMaster, addressMonitorEn, areaShared}, 6'h0);
        // mid-run reset: registers return to reset values, role follows the pin again
        reset = 1;
        repeat (2) @(posedge clk);
        #1;
        reset = 0;
        repeat (6) @(posedge clk);
        rd(BUS_CONTROL_ONE_ADDR, 32'h83f0);
        rd(BUS_CONTROL_TWO_ADDR, 32'h00fc);
        summarize;
    end
    initial
    begin
        #20000;
        mismatches++;
        summarize;
    end
endmodule
